/* omc_map.svh */
// Offsets, field positions, reset values and timing counts of the clock selector
`ifndef OMC_MAP_SVH
`define OMC_MAP_SVH
// Register byte offsets
`define OMC_ADDR_TUNE     8'h00
`define OMC_ADDR_CTRL     8'h04
`define OMC_ADDR_STAT     8'h08
// Field positions
`define OMC_TUNE_MSB      5
`define OMC_IFS_LSB       4
`define OMC_IFS_MSB       6
`define OMC_STAT_PLL      4
`define OMC_STAT_FAST     5
`define OMC_STAT_SLOW     6
`define OMC_STAT_READY    7
// Reset values
`define OMC_TUNE_RST      6'h00
`define OMC_IFS_RST       3'h0
// Frequency select codes
`define OMC_IFS_FAST      3'h7
`define OMC_IFS_SLOW      3'h0
// Rates in Hz and derived cycle counts
`define OMC_CLK_HZ        40000000
`define OMC_FAST_HZ       8000000
`define OMC_SLOW_HZ       31250
`define OMC_EXT_MAX_HZ    10000000
`define OMC_PLL_MULT      4
`define OMC_FAST_DIV      (`OMC_CLK_HZ / `OMC_FAST_HZ)
`define OMC_SLOW_DIV      (`OMC_CLK_HZ / `OMC_SLOW_HZ)
// Crystal start-up in oscillator edges; mode capture delay in clock cycles
`define OMC_OST_EDGES     1024
`define OMC_CAPT_CYCLES   2
`endif

/* omc_pkg.sv */
// Types shared by the clock selector
package omc_pkg;
  typedef enum logic [3:0] {
    OMC_LOW_POWER_CRYSTAL        = 4'h0,
    OMC_STANDARD_CRYSTAL         = 4'h1,
    OMC_HIGH_SPEED_CRYSTAL_MODE  = 4'h2,
    OMC_RESISTOR_CAPACITOR_OSC   = 4'h3,
    OMC_EXTERNAL_CLOCK_QUARTER_OUT = 4'h4,
    OMC_EXTERNAL_CLOCK_PIN_IO    = 4'h5,
    OMC_HIGH_SPEED_CRYSTAL_TIMES_FOUR = 4'h6,
    OMC_RESISTOR_CAPACITOR_PIN_IO = 4'h7,
    OMC_INTERNAL_OSC_BOTH_PINS_IO = 4'h8,
    OMC_INTERNAL_OSC_QUARTER_OUT = 4'h9
  } omc_mode_e;
  typedef enum logic [1:0] {
    OMC_ST_CAPTURE = 2'b00,
    OMC_ST_WAIT    = 2'b01,
    OMC_ST_RUN     = 2'b11
  } omc_state_e;
endpackage : omc_pkg

/* omc_clock_selector.sv */
// Oscillator mode decode, internal clock block and system clock selection
//
// Contract
// [RL1] Times-four mode multiplies the oscillator by four; 10 MHz in gives 40 MHz.
// [RL2] Multiplier is enabled only in the times-four mode.
// [RL3] External-clock modes run at once, with no start-up delay.
// [RL4] External-clock quarter mode drives oscillator divided by four on out pin.
// [RL5] External-clock pin mode gives the out pin to port A bit six.
// [RL6] RC mode drives oscillator divided by four on the out pin.
// [RL7] RC pin mode gives the out pin to port A bit six.
// [RL8] Fast 8 MHz source drives clock directly or via postscaler 125 kHz-4 MHz.
// [RL9] Fast source is enabled whenever a 125 kHz to 8 MHz clock is selected.
// [RL10] Slow source runs when internal block clocks system or a feature needs it.
// [RL11] Frequency select field chooses fast, slow or postscaled internal clock.
// [RL12] Code 111 fast direct, 000 slow direct, 110..001 give 4 MHz..125 kHz.
// [RL13] Internal quarter mode: clock/4 on out pin, in pin is port A bit seven.
// [RL14] Internal pin mode: in pin is port A bit seven, out pin bit six.
// [RL15] Six-bit tuning field is a two's-complement offset from calibration.
// [RL16] Tuning bits 7-6 read zero and ignore writes; bits clear at reset.
// [RL17] Slow source settles in 8 cycles, fast source in 1 ms after tuning.
// [RL18] No flag shows that a tuning change has settled; execution continues.
// [RL19] High-speed mode accepts a driven clock on the input pin.
// [RL20] Four-bit configuration field selects one of ten oscillator modes.
// [RL21] Quarter output comes from a free-running two-bit counter on the clock.
`timescale 1ns/1ps
`include "omc_map.svh"
module omc_clock_selector
  import omc_pkg::*;
(
  // Clock, reset, freeze
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Non-volatile configuration and feature enables
  input  wire logic [3:0]  osc_mode_config,
  input  wire logic        pwrt_en,
  input  wire logic        fscm_en,
  input  wire logic        watchdog_en,
  input  wire logic        two_speed_en,
  // Oscillator pins
  input  wire logic        primary_osc_in_pin_i,
  output logic             primary_osc_in_pin_o,
  output logic             primary_osc_in_pin_oe,
  input  wire logic        primary_osc_out_pin_i,
  output logic             primary_osc_out_pin_o,
  output logic             primary_osc_out_pin_oe,
  // Port A side of the freed pins
  input  wire logic        port_a_bit_six_out,
  input  wire logic        port_a_bit_six_oe,
  output logic             port_a_bit_six_in,
  input  wire logic        port_a_bit_seven_out,
  input  wire logic        port_a_bit_seven_oe,
  output logic             port_a_bit_seven_in,
  // Clock block outputs
  output logic             sys_clk_tick,
  output logic             sys_ready,
  output logic             pll_enable,
  output logic             fast_osc_enable,
  output logic             slow_osc_enable,
  output logic      [5:0]  tuning_field
);

  function automatic logic is_internal(input omc_mode_e m);
    is_internal = (m == OMC_INTERNAL_OSC_BOTH_PINS_IO) ||
                  (m == OMC_INTERNAL_OSC_QUARTER_OUT);
  endfunction : is_internal

  function automatic logic is_crystal(input omc_mode_e m);
    is_crystal = (m == OMC_LOW_POWER_CRYSTAL) ||
                 (m == OMC_STANDARD_CRYSTAL) ||
                 (m == OMC_HIGH_SPEED_CRYSTAL_MODE) ||
                 (m == OMC_HIGH_SPEED_CRYSTAL_TIMES_FOUR);
  endfunction : is_crystal

  // Synchronisers for every pin-side input
  logic [9:0] sync1_reg;
  logic [9:0] sync2_reg;
  logic [9:0] async_in;
  assign async_in = {primary_osc_out_pin_i, primary_osc_in_pin_i,
                     two_speed_en, watchdog_en, fscm_en, pwrt_en,
                     osc_mode_config};
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 10'h000;
      sync2_reg <= 10'h000;
    end else if (clk_en) begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  logic ext_lvl;
  logic primary_osc_out_pin_lvl;
  logic feature_on;
  assign ext_lvl    = sync2_reg[8];
  assign primary_osc_out_pin_lvl   = sync2_reg[9];
  assign feature_on = |sync2_reg[7:4];

  // Register file and bus state
  logic [5:0] tune_reg;
  logic [5:0] tune_next;
  logic [2:0] ifs_reg;
  logic [2:0] ifs_next;
  logic       wr_pend_reg;
  logic       wr_pend_next;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_addr_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic       bus_take;
  omc_mode_e  mode_reg;
  omc_mode_e  mode_next;
  omc_state_e state_reg;
  omc_state_e state_next;

  // Zero-wait slave; a frozen block holds the bus off
  assign bus_take  = hsel && hready && htrans[1];
  assign hreadyout = clk_en;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  always_comb begin
    tune_next    = tune_reg;
    ifs_next     = ifs_reg;
    wr_pend_next = bus_take && hwrite;
    wr_addr_next = haddr[7:0];
    rdata_next   = rdata_reg;
    if (wr_pend_reg) begin
      case (wr_addr_reg)
        `OMC_ADDR_TUNE: tune_next = hwdata[`OMC_TUNE_MSB:0]; // RL16 RL15
        `OMC_ADDR_CTRL: ifs_next = hwdata[`OMC_IFS_MSB:`OMC_IFS_LSB]; // RL11
        default:        tune_next = tune_reg;
      endcase
    end
    // Read data reflects a write finishing in the same cycle
    if (bus_take && !hwrite) begin
      rdata_next = 32'h0000_0000;
      case (haddr[7:0])
        `OMC_ADDR_TUNE: rdata_next[`OMC_TUNE_MSB:0] = tune_next; // RL16
        `OMC_ADDR_CTRL: rdata_next[`OMC_IFS_MSB:`OMC_IFS_LSB] = ifs_next;
        `OMC_ADDR_STAT: begin
          rdata_next[3:0]             = mode_reg;
          rdata_next[`OMC_STAT_PLL]   = pll_enable;
          rdata_next[`OMC_STAT_FAST]  = fast_osc_enable;
          rdata_next[`OMC_STAT_SLOW]  = slow_osc_enable;
          rdata_next[`OMC_STAT_READY] = sys_ready;
        end
        default:        rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tune_reg    <= `OMC_TUNE_RST; // RL16
      ifs_reg     <= `OMC_IFS_RST;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg   <= 32'h0000_0000;
    end else if (clk_en) begin
      tune_reg    <= tune_next;
      ifs_reg     <= ifs_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg   <= rdata_next;
    end
  end

  // Trim goes straight to the analog tuning; settling is analog only
  assign tuning_field = tune_reg; // RL15 RL17 RL18

  // Oscillator enables
  assign pll_enable      = (mode_reg == OMC_HIGH_SPEED_CRYSTAL_TIMES_FOUR); // RL2
  assign fast_osc_enable = (ifs_reg != `OMC_IFS_SLOW); // RL9
  assign slow_osc_enable = is_internal(mode_reg) || feature_on; // RL10

  // Oscillator edge, period measure for the multiplier
  logic       ext_prev_reg;
  logic       ext_rise;
  logic [7:0] per_cnt_reg;
  logic [7:0] per_cnt_next;
  logic [7:0] per_reg;
  logic [7:0] per_next;
  logic [7:0] q1;
  logic [7:0] q2;
  logic [7:0] q3;
  logic       pll_tick;
  assign ext_rise = ext_lvl && !ext_prev_reg; // RL19
  assign q1 = {2'b00, per_reg[7:2]};
  assign q2 = {1'b0, per_reg[7:2], 1'b0};
  assign q3 = q1 + q2;

  always_comb begin
    per_cnt_next = per_cnt_reg;
    per_next     = per_reg;
    if (ext_rise) begin
      per_cnt_next = 8'h01;
      per_next     = per_cnt_reg;
    end else if (per_cnt_reg != 8'hff) begin
      per_cnt_next = per_cnt_reg + 8'h01;
    end
  end

  // Oscillator edge plus three evenly spaced ticks between edges
  assign pll_tick = ext_rise || ((q1 != 8'h00) &&
                    ((per_cnt_reg == q1) || (per_cnt_reg == q2) ||
                     (per_cnt_reg == q3))); // RL1

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ext_prev_reg <= 1'b0;
      per_cnt_reg  <= 8'h00;
      per_reg      <= 8'h00;
    end else if (clk_en) begin
      ext_prev_reg <= ext_lvl;
      per_cnt_reg  <= per_cnt_next;
      per_reg      <= per_next;
    end
  end

  // Internal block: fast source, postscaler, slow source
  logic [2:0]  fast_cnt_reg;
  logic [2:0]  fast_cnt_next;
  logic [5:0]  post_cnt_reg;
  logic [5:0]  post_cnt_next;
  logic [10:0] slow_cnt_reg;
  logic [10:0] slow_cnt_next;
  logic        fast_tick;
  logic        slow_tick;
  logic        int_tick;
  logic [5:0]  post_mask;

  assign fast_tick = fast_osc_enable &&
                     (fast_cnt_reg == 3'(`OMC_FAST_DIV - 1)); // RL8
  assign slow_tick = slow_osc_enable &&
                     (slow_cnt_reg == 11'(`OMC_SLOW_DIV - 1));
  // Divide by two for code 110 up to by sixty-four for code 001
  assign post_mask = 6'(7'h7f >> ifs_reg); // RL12

  always_comb begin
    fast_cnt_next = fast_cnt_reg;
    post_cnt_next = post_cnt_reg;
    slow_cnt_next = slow_cnt_reg;
    if (fast_osc_enable) begin
      fast_cnt_next = fast_tick ? 3'h0 : fast_cnt_reg + 3'h1;
      if (fast_tick) begin
        post_cnt_next = post_cnt_reg + 6'h01;
      end
    end
    if (slow_osc_enable) begin
      slow_cnt_next = slow_tick ? 11'h000 : slow_cnt_reg + 11'h001;
    end
  end

  always_comb begin
    case (ifs_reg)
      `OMC_IFS_FAST: int_tick = fast_tick; // RL12
      `OMC_IFS_SLOW: int_tick = slow_tick; // RL12
      default: int_tick = fast_tick &&
                          ((post_cnt_reg & post_mask) == post_mask); // RL11
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fast_cnt_reg <= 3'h0;
      post_cnt_reg <= 6'h00;
      slow_cnt_reg <= 11'h000;
    end else if (clk_en) begin
      fast_cnt_reg <= fast_cnt_next;
      post_cnt_reg <= post_cnt_next;
      slow_cnt_reg <= slow_cnt_next;
    end
  end

  // Mode capture and crystal start-up
  logic [10:0] ost_cnt_reg;
  logic [10:0] ost_cnt_next;

  always_comb begin
    state_next   = state_reg;
    mode_next    = mode_reg;
    ost_cnt_next = ost_cnt_reg;
    case (state_reg)
      OMC_ST_CAPTURE: begin
        // Strap caught only after the synchroniser has filled
        ost_cnt_next = ost_cnt_reg + 11'h001;
        if (ost_cnt_reg == 11'(`OMC_CAPT_CYCLES)) begin
          mode_next    = omc_mode_e'(sync2_reg[3:0]); // RL20
          ost_cnt_next = 11'h000;
          state_next   = OMC_ST_WAIT;
        end
      end
      OMC_ST_WAIT: begin
        // Only crystals need the start-up count
        if (!is_crystal(mode_reg)) begin
          state_next = OMC_ST_RUN; // RL3
        end else if (ext_rise) begin
          ost_cnt_next = ost_cnt_reg + 11'h001;
          if (ost_cnt_reg == 11'(`OMC_OST_EDGES - 1)) begin
            state_next = OMC_ST_RUN;
          end
        end
      end
      OMC_ST_RUN: state_next = OMC_ST_RUN;
      default:    state_next = OMC_ST_CAPTURE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= OMC_ST_CAPTURE;
      mode_reg    <= OMC_LOW_POWER_CRYSTAL;
      ost_cnt_reg <= 11'h000;
    end else if (clk_en) begin
      state_reg   <= state_next;
      mode_reg    <= mode_next;
      ost_cnt_reg <= ost_cnt_next;
    end
  end

  assign sys_ready = (state_reg == OMC_ST_RUN);

  // System clock selection by mode
  always_comb begin
    sys_clk_tick = 1'b0;
    if (sys_ready && clk_en) begin
      if (pll_enable) begin
        sys_clk_tick = pll_tick; // RL1
      end else if (is_internal(mode_reg)) begin
        sys_clk_tick = int_tick; // RL8 RL11
      end else begin
        sys_clk_tick = ext_rise; // RL19
      end
    end
  end

  // Quarter output: free-running counter keeps duty near half
  logic [1:0] qtr_cnt_reg;
  logic [1:0] qtr_cnt_next;
  assign qtr_cnt_next = sys_clk_tick ? qtr_cnt_reg + 2'h1 : qtr_cnt_reg; // RL21
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      qtr_cnt_reg <= 2'h0;
    end else if (clk_en) begin
      qtr_cnt_reg <= qtr_cnt_next;
    end
  end

  // Pin ownership
  logic out_pin_qtr;
  logic out_pin_port;
  logic in_pin_port;
  assign out_pin_qtr  = (mode_reg == OMC_EXTERNAL_CLOCK_QUARTER_OUT) || // RL4
                        (mode_reg == OMC_RESISTOR_CAPACITOR_OSC) ||     // RL6
                        (mode_reg == OMC_INTERNAL_OSC_QUARTER_OUT);     // RL13
  assign out_pin_port = (mode_reg == OMC_EXTERNAL_CLOCK_PIN_IO) ||      // RL5
                        (mode_reg == OMC_RESISTOR_CAPACITOR_PIN_IO) ||  // RL7
                        (mode_reg == OMC_INTERNAL_OSC_BOTH_PINS_IO);    // RL14
  assign in_pin_port  = is_internal(mode_reg); // RL13 RL14

  always_comb begin
    primary_osc_out_pin_o  = 1'b0;
    primary_osc_out_pin_oe = 1'b0;
    port_a_bit_six_in      = 1'b0;
    if (out_pin_qtr) begin
      primary_osc_out_pin_o  = qtr_cnt_reg[1]; // RL21
      primary_osc_out_pin_oe = 1'b1;
    end else if (out_pin_port) begin
      primary_osc_out_pin_o  = port_a_bit_six_out;
      primary_osc_out_pin_oe = port_a_bit_six_oe;
      port_a_bit_six_in      = primary_osc_out_pin_lvl;
    end
  end

  assign primary_osc_in_pin_o  = in_pin_port && port_a_bit_seven_out;
  assign primary_osc_in_pin_oe = in_pin_port && port_a_bit_seven_oe;
  assign port_a_bit_seven_in   = in_pin_port && ext_lvl;

  // Checks
  property p_pll_only;
    @(posedge clock) disable iff (!nrst)
    pll_enable |-> (sync2_reg[3:0] == OMC_HIGH_SPEED_CRYSTAL_TIMES_FOUR);
  endproperty
  a_pll_only: assert property (p_pll_only) // RL2
    else $error("multiplier enabled outside times-four mode");

  property p_pll_edge;
    @(posedge clock) disable iff (!nrst)
    (clk_en && sys_ready && pll_enable && ext_rise) |-> sys_clk_tick;
  endproperty
  a_pll_edge: assert property (p_pll_edge) // RL1
    else $error("multiplier missed an oscillator edge");

  property p_ext_no_wait;
    @(posedge clock) disable iff (!nrst || !clk_en)
    (state_reg == OMC_ST_WAIT && !is_crystal(mode_reg)) |=> sys_ready;
  endproperty
  a_ext_no_wait: assert property (p_ext_no_wait) // RL3
    else $error("start-up delay applied in a clock mode");

  property p_qtr_pin;
    @(posedge clock) disable iff (!nrst)
    out_pin_qtr |-> (primary_osc_out_pin_oe &&
                     primary_osc_out_pin_o == qtr_cnt_reg[1]);
  endproperty
  a_qtr_pin: assert property (p_qtr_pin) // RL4
    else $error("quarter output not on out pin");

  property p_port_six;
    @(posedge clock) disable iff (!nrst)
    out_pin_port |-> (primary_osc_out_pin_oe == port_a_bit_six_oe &&
                      port_a_bit_six_in == primary_osc_out_pin_lvl);
  endproperty
  a_port_six: assert property (p_port_six) // RL5
    else $error("out pin not handed to port bit six");

  property p_fast_en;
    @(posedge clock) disable iff (!nrst || !clk_en)
    (ifs_reg != `OMC_IFS_SLOW) |-> ##[0:4] fast_tick || fast_cnt_reg != 3'h0;
  endproperty
  a_fast_en: assert property (p_fast_en) // RL9
    else $error("fast source idle while selected");

  property p_slow_en;
    @(posedge clock) disable iff (!nrst)
    feature_on |-> slow_osc_enable;
  endproperty
  a_slow_en: assert property (p_slow_en) // RL10
    else $error("slow source off while a feature needs it");

  property p_tune_read;
    @(posedge clock) disable iff (!nrst || !clk_en)
    (bus_take && !hwrite && haddr[7:0] == `OMC_ADDR_TUNE && !wr_pend_reg)
      |=> (hrdata[31:6] == 26'h0 && hrdata[5:0] == $past(tune_reg));
  endproperty
  a_tune_read: assert property (p_tune_read) // RL16
    else $error("tuning read back wrong");

  property p_qtr_count;
    @(posedge clock) disable iff (!nrst)
    (clk_en && sys_clk_tick) |=> (qtr_cnt_reg == $past(qtr_cnt_reg) + 2'h1);
  endproperty
  a_qtr_count: assert property (p_qtr_count) // RL21
    else $error("quarter counter missed a tick");

endmodule : omc_clock_selector

/* omc_osc_model.sv */
// External clock source that drives the primary oscillator pin
`timescale 1ns/1ps
module omc_osc_model (
  // Control from the bench
  input  wire logic run,
  input  wire logic idle_lvl,
  input  wire logic [31:0] half_ns,
  // Oscillator pin
  output logic      osc_pin
);
  logic osc_q;

  // Driven clock in place of a crystal; stands low while stopped
  always begin
    if (run) begin
      #(half_ns) osc_q = ~osc_q;
    end else begin
      osc_q = 1'b0;
      @(run);
      // Offset keeps pin edges clear of the system clock edge
      #7;
    end
  end

  // Stopped source releases the pin to the port level
  assign osc_pin = run ? osc_q : idle_lvl;
endmodule : omc_osc_model

/* tb_top.sv */
// Self-checking bench for the oscillator mode clock selector
`timescale 1ns/1ps
`include "omc_map.svh"
module tb_top;
  import omc_pkg::*;
  localparam logic [31:0] A_TUNE = {24'h0, `OMC_ADDR_TUNE};
  localparam logic [31:0] A_CTRL = {24'h0, `OMC_ADDR_CTRL};
  localparam logic [31:0] A_STAT = {24'h0, `OMC_ADDR_STAT};
  logic        clock, nrst, clk_en, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  mode, feat;
  logic        osc_run, idle_lvl, osc_pin, pin1, pin2, out_i;
  logic        out_o, out_oe, in_o, in_oe, s6o, s6e, s6i, s7o, s7e, s7i;
  logic        tick, ready, pll, fast, slow, rd_ph;
  logic [5:0]  tune;
  logic [31:0] exp_q[$];
  int          miscompares, num_checks, n, k, seed_v;

  // Pin levels from every party's enable
  assign pin1   = in_oe ? in_o : osc_pin;
  assign pin2   = out_oe ? out_o : out_i;
  assign hready = hreadyout;

  omc_clock_selector u_dut (
    .clock(clock), .nrst(nrst), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .osc_mode_config(mode),
    .pwrt_en(feat[0]), .fscm_en(feat[1]), .watchdog_en(feat[2]),
    .two_speed_en(feat[3]), .primary_osc_in_pin_i(pin1),
    .primary_osc_in_pin_o(in_o), .primary_osc_in_pin_oe(in_oe),
    .primary_osc_out_pin_i(pin2), .primary_osc_out_pin_o(out_o),
    .primary_osc_out_pin_oe(out_oe), .port_a_bit_six_out(s6o),
    .port_a_bit_six_oe(s6e), .port_a_bit_six_in(s6i),
    .port_a_bit_seven_out(s7o), .port_a_bit_seven_oe(s7e),
    .port_a_bit_seven_in(s7i), .sys_clk_tick(tick), .sys_ready(ready),
    .pll_enable(pll), .fast_osc_enable(fast), .slow_osc_enable(slow),
    .tuning_field(tune));

  omc_osc_model u_osc (.run(osc_run), .idle_lvl(idle_lvl),
    .half_ns(32'h0000_00c8), .osc_pin(osc_pin));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic hang();
    miscompares++;
    $display("FAIL %0t wait limit reached", $time);
    conclude();
  endtask : hang

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, want);
    end
  endtask : chk

  // Read data is compared at the edge that closes the data phase
  always @(posedge clock) begin
    if (rd_ph === 1'b1 && hready === 1'b1) begin
      chk(hresp, 1'b0);
      chk(hrdata, exp_q.pop_front());
    end
  end

  // Single word transfer; a read notes its expected data first
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    int t;
    @(posedge clock);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    t = 0;
    do begin @(posedge clock); t++; end while (hready !== 1'b1 && t < 50);
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    if (!w) begin
      exp_q.push_back(d);
      rd_ph <= 1'b1;
    end
    do begin @(posedge clock); t++; end while (hready !== 1'b1 && t < 100);
    rd_ph <= 1'b0;
    if (t >= 100) hang();
  endtask : bus

  task automatic do_reset(input logic [3:0] m, input logic r);
    @(posedge clock);
    nrst    <= 1'b0;
    mode    <= m;
    osc_run <= r;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
  endtask : do_reset

  task automatic wait_ready(input int lim, output int w);
    w = 0;
    do begin @(posedge clock); w++; end while (ready !== 1'b1 && w < lim);
  endtask : wait_ready

  task automatic tick_gap(output int g);
    g = 0;
    do begin @(posedge clock); g++; end while (tick !== 1'b1 && g < 3000);
    g = 0;
    do begin @(posedge clock); g++; end while (tick !== 1'b1 && g < 3000);
    if (g >= 3000) hang();
  endtask : tick_gap

  // Ticks between two rises of the quarter output
  task automatic quarter_ticks(output int q);
    int t, r;
    logic p;
    t = 0;
    r = 0;
    q = 0;
    p = 1'b1;
    while (r < 2 && t < 20000) begin
      @(posedge clock);
      t++;
      if (r == 1 && tick === 1'b1) q++;
      if (p === 1'b0 && out_o === 1'b1) r++;
      p = out_o;
    end
    if (t >= 20000) hang();
  endtask : quarter_ticks

  task automatic mode_case(input logic [3:0] m);
    logic [5:0] r;
    logic qm, pm, im;
    r  = 6'($urandom());
    qm = m inside {4'h3, 4'h4, 4'h9};
    pm = m inside {4'h5, 4'h7, 4'h8};
    im = m inside {4'h8, 4'h9};
    s6o      <= r[0];
    s6e      <= r[1];
    out_i    <= r[2];
    s7o      <= r[3];
    s7e      <= r[4];
    idle_lvl <= r[5];
    do_reset(m, !im);
    wait_ready(12, n);
    chk(n < 8, m > 4'h2);
    repeat (4) @(posedge clock);
    chk(pll, 1'b0);
    chk(slow, im);
    chk(out_oe, qm | (pm & r[1]));
    if (pm & r[1]) chk(out_o, r[0]);
    chk(s6i, pm & (r[1] ? r[0] : r[2]));
    chk(in_oe, im & r[4]);
    if (im & r[4]) chk(in_o, r[3]);
    chk(s7i, im & (r[4] ? r[3] : r[5]));
    if (m > 4'h2) bus(1'b0, A_STAT, {24'h0, 1'b1, im, 2'b00, m});
    if (qm) begin
      quarter_ticks(k);
      chk(k, 4);
    end
  endtask : mode_case

  initial begin
    logic [3:0]  ml[9];
    logic [31:0] tv[5];
    int          p;
    ml = '{4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'h0, 4'h1, 4'h2};
    tv = '{32'h1f, 32'h20, 32'h0, 32'hff, 32'h0};
    nrst = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b1;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    rd_ph = 1'b0;
    mode = 4'h4;
    feat = 4'h0;
    osc_run = 1'b0;
    idle_lvl = 1'b0;
    out_i = 1'b0;
    {s6o, s6e, s7o, s7e} = 4'h0;
    miscompares = 0;
    num_checks = 0;
    seed_v = $urandom(32'hd4917149);
    foreach (ml[i]) mode_case(ml[i]);
    do_reset(4'h6, 1'b1);
    wait_ready(40000, n);
    chk(n < 40000, 1'b1);
    chk(pll, 1'b1);
    k = 0;
    repeat (64) begin
      @(posedge clock);
      k += int'(tick === 1'b1);
    end
    chk(k, 16);
    do_reset(4'h4, 1'b1);
    for (int i = 0; i < 4; i++) begin
      feat <= 4'(1 << i);
      repeat (5) @(posedge clock);
      chk(slow, 1'b1);
      feat <= 4'h0;
      repeat (5) @(posedge clock);
      chk(slow, 1'b0);
    end
    do_reset(4'h9, 1'b0);
    wait_ready(12, n);
    bus(1'b0, A_TUNE, 32'h0);
    bus(1'b1, 32'h10, 32'hffffffff);
    bus(1'b0, 32'h10, 32'h0);
    bus(1'b0, 32'h0c, 32'h0);
    tv[4] = $urandom();
    foreach (tv[i]) begin
      bus(1'b1, A_TUNE, tv[i]);
      bus(1'b0, A_TUNE, tv[i] & 32'h3f);
      chk(tune, tv[i][5:0]);
      chk(ready, 1'b1);
    end
    for (int c = 7; c >= 0; c--) begin
      p = (c == 7) ? `OMC_FAST_DIV : (c == 0) ? `OMC_SLOW_DIV :
          `OMC_FAST_DIV << (7 - c);
      bus(1'b1, A_CTRL, 32'(c) << 4);
      bus(1'b0, A_CTRL, 32'(c) << 4);
      chk(fast, c != 0);
      bus(1'b0, A_STAT, {24'h0, 2'b11, (c != 0), 5'h09});
      tick_gap(n);
      tick_gap(n);
      chk(n, p);
      // Frozen block must neither tick nor accept the bus
      if (c == 7) begin
        clk_en <= 1'b0;
        k = 0;
        repeat (20) begin
          @(posedge clock);
          k += int'(tick === 1'b1 || hready !== 1'b0);
        end
        clk_en <= 1'b1;
        chk(k, 0);
      end
    end
    conclude();
  end
endmodule : tb_top
